// ---- common/eecc_pkg.sv ----
// Constants, register map and field layout of the EEPROM command control block.
// Assumes a 100 MHz system clock; included by both design modules.
package eecc_pkg;
  localparam logic [7:0] CMD_OFS   = 8'hB0;
  localparam logic [7:0] DATA_OFS  = 8'hB4;
  localparam logic [7:0] STAT_OFS  = 8'hB8;
  localparam logic [7:0] CLR_OFS   = 8'hBC;
  localparam logic [7:0] IEN_OFS   = 8'hC0;
  localparam logic [7:0] MACLO_OFS = 8'hC4;
  localparam logic [7:0] MACHI_OFS = 8'hC8;
  localparam int BUSY_BIT = 31;
  localparam int OP_LSB   = 28;
  localparam int OP_W     = 3;
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 8;
  localparam logic [2:0] OP_READ   = 3'h0;
  localparam logic [2:0] OP_WRITE  = 3'h3;
  localparam logic [2:0] OP_WRAL   = 3'h4;
  localparam logic [2:0] OP_RELOAD = 3'h7;
  localparam int EV_DONE = 0;
  localparam int EV_TMO  = 1;
  localparam int EV_LOAD = 2;
  localparam int EV_W    = 3;
  localparam logic [7:0] LOAD_BASE  = 8'h01;
  localparam logic [2:0] LOAD_LAST  = 3'h5;
  localparam logic [2:0] RESET_OP   = 3'h0;
  localparam int CLK_PERIOD_NS  = 10;
  localparam int SCK_HALF_NS    = 500;
  localparam int SCK_HALF_CYC   = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMEOUT_US     = 1000;
  localparam int TIMEOUT_CYC    = TIMEOUT_US * 1000 / CLK_PERIOD_NS;
  localparam int WAIT_SETTLE_CYC = 8;
endpackage

// ---- common/eecc_if.sv ----
// Command channel between the register controller and the serial engine.
// Assumes both ends run on sys_clk.
`timescale 1ns/1ns
`default_nettype none
interface eecc_if;
  logic       start;
  logic [2:0] op;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       done;
  logic       timed_out;
  modport ctrl (output start, op, addr, wdata, input rdata, done, timed_out);
  modport eng  (input start, op, addr, wdata, output rdata, done, timed_out);
endinterface
`default_nettype wire

// ---- core/eecc_engine.sv ----
// Serial EEPROM engine: shifts a start bit, opcode, address and data out,
// shifts read data in, and waits for the ready level after a write.
// Assumes the EEPROM data pin is asynchronous and start comes only when idle.
`timescale 1ns/1ns
`default_nettype none
module eecc_engine
  import eecc_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
  parameter int HALF_CYCLES    = SCK_HALF_CYC
) (
  input  wire logic sys_clk,
  input  wire logic reset,
  eecc_if.eng       cmd,
  output logic      eeprom_cs,
  output logic      eeprom_sck,
  output logic      eeprom_dout,
  input  wire logic eeprom_din
);
  typedef enum logic [2:0] {E_IDLE, E_SHIFT, E_RDATA, E_GAP, E_WAIT, E_FIN} eecc_est_t;
  typedef struct packed {
    eecc_est_t   st;
    logic [15:0] div;
    logic [4:0]  bitn;
    logic [19:0] sh;
    logic [7:0]  rx;
    logic [31:0] tmo;
    logic        cs, sck, dout, s1, s2, s3, din, done, tflag;
  } eecc_eng_t;
  eecc_eng_t q, n;
  logic tick;

  always_comb begin
    n = q;
    n.done = 1'b0;
    n.s1 = eeprom_din;
    n.s2 = q.s1;
    n.s3 = q.s2;
    if (q.s2 == q.s3) begin
      n.din = q.s3;
    end
    tick = (q.div == 16'(HALF_CYCLES - 1));
    n.div = tick ? 16'h0000 : q.div + 16'h0001;
    unique case (q.st)
      E_IDLE: begin
        if (cmd.start) begin
          n.sh = {1'b1, cmd.op, cmd.addr, cmd.wdata};
          n.bitn = (cmd.op == OP_WRITE || cmd.op == OP_WRAL) ? 5'h14 : 5'h0C;
          n.cs = 1'b1;
          n.dout = 1'b1;
          n.div = 16'h0000;
          n.tflag = 1'b0;
          n.st = E_SHIFT;
        end
      end
      E_SHIFT: if (tick) begin
        if (!q.sck) begin
          n.sck = 1'b1;
        end else begin
          n.sck = 1'b0;
          n.sh = {q.sh[18:0], 1'b0};
          n.dout = q.sh[18];
          n.bitn = q.bitn - 5'h01;
          if (q.bitn == 5'h01) begin
            n.dout = 1'b0;
            if (cmd.op == OP_READ) begin
              n.bitn = 5'h08;
              n.st = E_RDATA;
            end else begin
              n.cs = 1'b0;
              n.st = E_GAP;
            end
          end
        end
      end
      E_RDATA: if (tick) begin
        if (!q.sck) begin
          n.sck = 1'b1;
          n.rx = {q.rx[6:0], q.din};
          n.bitn = q.bitn - 5'h01;
        end else begin
          n.sck = 1'b0;
          if (q.bitn == 5'h00) begin
            n.st = E_FIN;
          end
        end
      end
      E_GAP: if (tick) begin
        n.cs = 1'b1;
        n.tmo = 32'h0000_0000;
        n.st = E_WAIT;
      end
      E_WAIT: begin
        n.tmo = q.tmo + 32'h0000_0001;
        // Ignore the line until the synchroniser has flushed its level from before the select
        if (q.din && q.tmo >= 32'(WAIT_SETTLE_CYC)) begin
          n.st = E_FIN;
        end else if (q.tmo == 32'(TIMEOUT_CYCLES - 1)) begin
          n.tflag = 1'b1;
          n.st = E_FIN;
        end
      end
      E_FIN: begin
        n.cs = 1'b0;
        n.sck = 1'b0;
        n.done = 1'b1;
        n.st = E_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign cmd.done      = q.done;
  assign cmd.timed_out = q.tflag;
  assign cmd.rdata     = q.rx;
  assign eeprom_cs     = q.cs;
  assign eeprom_sck    = q.sck;
  assign eeprom_dout   = q.dout;

  chk_wait_bounded: assert property (@(posedge sys_clk) disable iff (reset)
    (q.st == E_WAIT) |-> (q.tmo < 32'(TIMEOUT_CYCLES)))
    else $error("ready wait passed its timeout");
endmodule
`default_nettype wire

// ---- core/eecc_top.sv ----
// EEPROM command control: command and data registers, busy handshake,
// station address load after reset, interrupt status.
// Assumes a one-cycle register port master on sys_clk and a serial EEPROM on the pins.
// Notes on behaviour
// - Writing one to the busy bit starts the selected operation at the address in the same register; a reload ignores the address.
// - Busy stays set while the operation runs, and for a read clears only once the data register holds the result.
// - A write to an absent EEPROM keeps busy set until the timeout expires, and then busy clears.
// - After reset busy reads as one while the station address loads, and clears when the load ends either way.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module eecc_top
  import eecc_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             irq,
  output logic      [47:0] station_addr,
  output logic             station_valid,
  output logic             eeprom_cs,
  output logic             eeprom_sck,
  output logic             eeprom_dout,
  input  wire logic        eeprom_din
);
  typedef enum logic [1:0] {T_ISSUE, T_LOAD, T_IDLE, T_RUN} eecc_tst_t;
  typedef struct packed {
    eecc_tst_t       st;
    logic            busy;
    logic [2:0]      op;
    logic [7:0]      addr;
    logic [7:0]      data;
    logic [EV_W-1:0] stat;
    logic [EV_W-1:0] ien;
    logic [47:0]     mac;
    logic            mac_ok;
    logic [2:0]      idx;
    logic            start;
    logic [31:0]     rdata;
  } eecc_top_t;
  eecc_top_t q, n;
  eecc_if bus ();
  logic            cmd_wr;
  logic            load_phase;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] clr;

  assign cmd_wr = reg_wr && (reg_addr == CMD_OFS);

  always_comb begin
    n = q;
    n.start = 1'b0;
    n.rdata = 32'h0000_0000;
    ev = '0;
    clr = (reg_wr && reg_addr == CLR_OFS) ? reg_wdata[EV_W-1:0] : '0;
    unique case (q.st)
      T_ISSUE: begin
        n.start = 1'b1;
        n.st = T_LOAD;
      end
      T_LOAD: if (bus.done) begin
        n.mac[q.idx*8 +: 8] = bus.rdata;
        n.idx = q.idx + 3'h1;
        n.st = T_ISSUE;
        if (bus.timed_out) begin
          n.mac_ok = 1'b0;
        end
        if (q.idx == LOAD_LAST || bus.timed_out) begin
          n.busy = 1'b0;
          n.st = T_IDLE;
          ev[EV_LOAD] = 1'b1;
        end
      end
      T_IDLE: begin
        if (cmd_wr) begin
          n.op = reg_wdata[OP_LSB +: OP_W];
          n.addr = reg_wdata[ADDR_W-1:0];
          if (reg_wdata[BUSY_BIT]) begin
            n.busy = 1'b1;
            if (reg_wdata[OP_LSB +: OP_W] == OP_RELOAD) begin
              n.idx = 3'h0;
              n.mac_ok = 1'b1;
              n.st = T_ISSUE;
            end else begin
              n.start = 1'b1;
              n.st = T_RUN;
            end
          end
        end
        if (reg_wr && reg_addr == DATA_OFS) begin
          n.data = reg_wdata[DATA_W-1:0];
        end
      end
      T_RUN: if (bus.done) begin
        n.busy = 1'b0;
        n.st = T_IDLE;
        if (q.op == OP_READ) begin
          n.data = bus.rdata;
        end
        ev[EV_DONE] = 1'b1;
        ev[EV_TMO] = bus.timed_out;
      end
    endcase
    if (reg_wr && reg_addr == IEN_OFS) begin
      n.ien = reg_wdata[EV_W-1:0];
    end
    n.stat = (q.stat & ~clr) | ev;
    if (reg_rd) begin
      unique case (reg_addr)
        CMD_OFS:   n.rdata = {q.busy, q.op, 20'h00000, q.addr};
        DATA_OFS:  n.rdata = {24'h000000, q.data};
        STAT_OFS:  n.rdata = {29'h00000000, q.stat};
        IEN_OFS:   n.rdata = {29'h00000000, q.ien};
        MACLO_OFS: n.rdata = q.mac[31:0];
        MACHI_OFS: n.rdata = {q.mac_ok, 15'h0000, q.mac[47:32]};
        default:   n.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      q <= '0;
      q.st <= T_ISSUE;
      q.busy <= 1'b1;
      q.mac_ok <= 1'b1;
      q.op <= RESET_OP;
    end else begin
      q <= n;
    end
  end

  assign bus.start     = q.start;
  // Load frames read the station bytes without disturbing the host's command fields
  assign load_phase    = (q.st == T_ISSUE) || (q.st == T_LOAD);
  assign bus.op        = load_phase ? OP_READ : q.op;
  assign bus.addr      = load_phase ? LOAD_BASE + {5'h00, q.idx} : q.addr;
  assign bus.wdata     = q.data;
  assign reg_rdata     = q.rdata;
  assign irq           = |(q.stat & q.ien);
  assign station_addr  = q.mac;
  assign station_valid = q.mac_ok && !q.busy;

  eecc_engine #(
    .TIMEOUT_CYCLES (TIMEOUT_CYCLES),
    .HALF_CYCLES    (SCK_HALF_CYC)
  ) u_engine (
    .sys_clk     (sys_clk),
    .reset       (reset),
    .cmd         (bus),
    .eeprom_cs   (eeprom_cs),
    .eeprom_sck  (eeprom_sck),
    .eeprom_dout (eeprom_dout),
    .eeprom_din  (eeprom_din)
  );

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  chk_start_busy: assert property (
    (q.st == T_IDLE && cmd_wr && reg_wdata[BUSY_BIT] && reg_wdata[30:28] != OP_RELOAD)
      |=> (q.busy && q.start && q.op == $past(reg_wdata[30:28])))
    else $error("busy write did not start the operation");
  chk_busy_hold: assert property (
    (q.st == T_RUN && !bus.done) |=> q.busy)
    else $error("busy dropped while operation ran");
  chk_read_data: assert property (
    (q.st == T_RUN && bus.done && q.op == OP_READ) |=> (!q.busy && q.data == $past(bus.rdata)))
    else $error("read finished without data");
  chk_timeout_clear: assert property (
    (q.st == T_RUN && bus.done && bus.timed_out) |=> (!q.busy && q.stat[EV_TMO]))
    else $error("timeout did not release busy");
  chk_reset_busy: assert property (
    $past(reset) |-> (q.busy && q.st == T_ISSUE))
    else $error("busy low after reset");
  chk_load_end: assert property (
    (q.st == T_LOAD && bus.done && q.idx == LOAD_LAST) |=> (!q.busy && q.st == T_IDLE))
    else $error("load end kept busy");
  chk_cmd_locked: assert property (
    (q.busy && cmd_wr) |=> (q.op == $past(q.op) && q.addr == $past(q.addr)))
    else $error("command changed while busy");
  chk_irq_level: assert property (
    (q.stat[EV_DONE] && q.ien[EV_DONE]) |-> irq)
    else $error("enabled event gave no interrupt");
  chk_reload_start: assert property (
    (q.st == T_IDLE && cmd_wr && reg_wdata[BUSY_BIT] && reg_wdata[30:28] == OP_RELOAD)
      |=> (q.busy && q.st == T_ISSUE && q.idx == 3'h0))
    else $error("reload command did not start the load");
  chk_idle_free: assert property (
    (q.st == T_IDLE) |-> !q.busy)
    else $error("busy set with no operation running");
  chk_busy_readback: assert property (
    (reg_rd && reg_addr == CMD_OFS) |=> (reg_rdata[BUSY_BIT] == $past(q.busy)))
    else $error("command read lost the busy bit");
  chk_load_busy: assert property (
    (q.st == T_ISSUE || q.st == T_LOAD) |-> q.busy)
    else $error("busy low during station load");
  chk_load_valid: assert property (
    (q.st == T_LOAD && bus.done && q.idx == LOAD_LAST && !bus.timed_out) |=> station_valid)
    else $error("clean load left station address invalid");
  chk_data_locked: assert property (
    (q.busy && reg_wr && reg_addr == DATA_OFS && !bus.done) |=> (q.data == $past(q.data)))
    else $error("data register changed while busy");
  chk_start_pulse: assert property (
    q.start |=> !q.start)
    else $error("engine start held longer than one cycle");
  chk_stat_sticky: assert property (
    (|(q.stat & ~clr)) |=> ((q.stat & $past(q.stat & ~clr)) == $past(q.stat & ~clr)))
    else $error("status bit lost without a clear");
  chk_rdata_quiet: assert property (
    !reg_rd |=> (reg_rdata == 32'h0000_0000))
    else $error("read data present without a read");
endmodule
`default_nettype wire

// ---- verification/eecc_eeprom_model.sv ----
// Behavioural serial EEPROM on the engine pins.
// Assumes sys_clk oversamples sck; present low leaves din stuck low.
`timescale 1ns/1ns
`default_nettype none
module eecc_eeprom_model (
  input  wire logic sys_clk,
  input  wire logic present,
  input  wire logic cs,
  input  wire logic sck,
  input  wire logic dout,
  output logic      din
);
  logic [7:0]  mem [256];
  logic [19:0] sh = 20'h0;
  logic [7:0]  rb = 8'h0;
  logic [2:0]  op = 3'h0;
  logic        cs_q = 1'h0;
  logic        sck_q = 1'h0;
  logic        drive = 1'h0;
  logic        rdy = 1'h0;
  logic        pend = 1'h0;
  logic        noise = 1'h0;
  int          n = 0;
  int          cnt = 0;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'hA0 ^ i[7:0];
  // Undriven line toggles so a stale level never reads as data or ready
  always @(negedge sys_clk) begin
    din <= !present ? 1'h0 : rdy ? (cnt > 20) : drive ? rb[7] : noise;
  end
  always @(posedge sys_clk) begin
    noise = ~noise;
    cnt = cnt + 1;
    if (cs && !cs_q) begin
      n = 0;
      rdy = pend;
      pend = 1'h0;
      cnt = 0;
    end
    if (!cs && cs_q) begin
      pend = !rdy && n >= 12 && op != 3'h0;
      rdy = 1'h0;
      drive = 1'h0;
    end
    if (cs && sck && !sck_q && !rdy) begin
      if (drive) rb = rb << 1;
      else begin
        sh = {sh[18:0], dout};
        n = n + 1;
        if (n == 12) begin
          op = sh[10:8];
          rb = mem[sh[7:0]];
          drive = (op == 3'h0);
        end
        if (n == 20 && op == 3'h3 && present) mem[sh[15:8]] = sh[7:0];
        if (n == 20 && op == 3'h4 && present) for (int i = 0; i < 256; i++) mem[i] = sh[7:0];
      end
    end
    cs_q = cs;
    sck_q = sck;
  end
endmodule
`default_nettype wire

// ---- verification/test_eecc_top.sv ----
// Self-checking bench for the EEPROM command control block.
// Assumes the EEPROM model on the pins and a short timeout parameter.
`timescale 1ns/1ns
`default_nettype none
module test_eecc_top
  import eecc_pkg::*;
;
  localparam int TMO = 200;
  logic        sys_clk = 1'h0;
  logic        reset = 1'h1;
  logic [7:0]  reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'h0;
  logic        reg_rd = 1'h0;
  logic        rd_d = 1'h0;
  logic        present = 1'h1;
  logic [31:0] reg_rdata;
  logic [31:0] v;
  logic        irq;
  logic [47:0] station_addr;
  logic        station_valid;
  logic        cs;
  logic        sck;
  logic        dout;
  logic        din;
  logic [7:0]  mir [256];
  logic [32:0] exp_q [$];
  logic [7:0]  a;
  logic [7:0]  d;
  int          errors = 0;
  int          samples_checked = 0;
  int          n;
  int          nw;
  eecc_top #(.TIMEOUT_CYCLES(TMO)) dut (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .station_addr(station_addr), .station_valid(station_valid), .eeprom_cs(cs), .eeprom_sck(sck),
    .eeprom_dout(dout), .eeprom_din(din));
  eecc_eeprom_model mdl (.sys_clk(sys_clk), .present(present), .cs(cs), .sck(sck), .dout(dout), .din(din));
  task automatic check(input logic [47:0] s, input logic [47:0] e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic finish_test();
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    reg_addr <= ad;
    reg_wdata <= wd;
    reg_wr <= 1'h1;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic c);
    reg_addr <= ad;
    reg_rd <= 1'h1;
    exp_q.push_back({c, e});
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    @(negedge sys_clk);
    v = reg_rdata;
    @(posedge sys_clk);
  endtask
  // Poll busy under a bound, counting cycles
  task automatic idle();
    n = 0;
    do begin
      rd(CMD_OFS, 32'h0, 1'h0);
      n += 2;
    end while (v[BUSY_BIT] !== 1'h0 && n < 30000);
    if (n >= 30000) check(48'h1, 48'h0);
  endtask
  function automatic logic [47:0] st();
    return {mir[6], mir[5], mir[4], mir[3], mir[2], mir[1]};
  endfunction
  task automatic load_chk();
    rd(CMD_OFS, 32'h0, 1'h0);
    check(v[BUSY_BIT], 1'h1);
    idle();
    check(station_addr, st());
    check(station_valid, 1'h1);
    rd(MACHI_OFS, {1'h1, 15'h0, mir[6], mir[5]}, 1'h1);
    rd(STAT_OFS, 32'h4, 1'h1);
    wr(CLR_OFS, 32'h7);
  endtask
  always @(posedge sys_clk) begin
    rd_d <= reg_rd;
    if (rd_d) begin
      if (exp_q[0][32]) check(reg_rdata, exp_q[0][31:0]);
      void'(exp_q.pop_front());
    end
  end
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    #1000000;
    check(48'h1, 48'h0);
    finish_test();
  end
  initial begin
    void'($urandom(32'h3480714C));
    for (int i = 0; i < 256; i++) mir[i] = 8'hA0 ^ i[7:0];
    repeat (8) @(posedge sys_clk);
    reset <= 1'h0;
    load_chk();
    wr(CMD_OFS, {4'h3, 20'h0, 8'h22});
    repeat (20) @(posedge sys_clk);
    rd(CMD_OFS, {4'h3, 20'h0, 8'h22}, 1'h1);
    for (int op = 0; op < 8; op++) begin
      a = 8'($urandom_range(255, 16));
      d = 8'($urandom);
      wr(DATA_OFS, {24'h0, d});
      wr(CMD_OFS, {1'h1, op[2:0], 20'h0, a});
      rd(CMD_OFS, {1'h1, op[2:0], 20'h0, a}, 1'h1);
      wr(CMD_OFS, {4'h8, 20'h0, ~a});
      wr(DATA_OFS, {24'h0, ~d});
      idle();
      if (op == 3) nw = n;
      if (op == 3) mir[a] = d;
      if (op == 4) for (int i = 0; i < 256; i++) mir[i] = d;
      rd(CMD_OFS, {1'h0, op[2:0], 20'h0, a}, 1'h1);
      rd(DATA_OFS, {24'h0, (op == 0) ? mir[a] : d}, 1'h1);
      rd(STAT_OFS, (op == 7) ? 32'h4 : 32'h1, 1'h1);
      wr(CLR_OFS, 32'h7);
    end
    check(station_addr, st());
    present <= 1'h0;
    wr(CMD_OFS, {4'hB, 20'h0, a});
    idle();
    check((n - nw) inside {[TMO - 60:TMO + 20]}, 1'h1);
    present <= 1'h1;
    rd(STAT_OFS, 32'h3, 1'h1);
    check(irq, 1'h0);
    wr(IEN_OFS, 32'h2);
    check(irq, 1'h1);
    wr(CLR_OFS, 32'h2);
    check(irq, 1'h0);
    rd(STAT_OFS, 32'h1, 1'h1);
    rd(IEN_OFS, 32'h2, 1'h1);
    rd(CLR_OFS, 32'h0, 1'h1);
    rd(8'h04, 32'h0, 1'h1);
    wr(CMD_OFS, {4'h8, 20'h0, 8'h40});
    repeat (300) @(posedge sys_clk);
    reset <= 1'h1;
    repeat (8) @(posedge sys_clk);
    check(station_valid, 1'h0);
    reset <= 1'h0;
    load_chk();
    finish_test();
  end
endmodule
`default_nettype wire
